// *** rtl/time_unit_cfg_pkg.sv ***
// Package with the time unit configuration register map, field layouts and reset values
`default_nettype none

package time_unit_cfg_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_INITIAL_OFFSETS   = 8'hA8;
    localparam logic [ADDR_W-1:0] OFS_IDLE_OFFSET_START = 8'hAC;
    localparam logic [ADDR_W-1:0] OFS_DELAY_DECODE      = 8'hB0;
    localparam logic [ADDR_W-1:0] OFS_STARTUP_DRIFT     = 8'hB4;
    localparam logic [ADDR_W-1:0] OFS_STATIC_SLOT       = 8'hB8;

    // ------------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       rsv1;
        logic [6:0] macro_init_offset_b;
        logic       rsv0;
        logic [6:0] macro_init_offset_a;
        logic [7:0] micro_init_offset_b;
        logic [7:0] micro_init_offset_a;
    } initial_offsets_type;

    typedef struct packed {
        logic [1:0]  rsv1;
        logic [13:0] offset_corr_start;
        logic [1:0]  rsv0;
        logic [13:0] idle_time_start;
    } idle_offset_start_type;

    typedef struct packed {
        logic [7:0] primary_ref_adjust;
        logic [2:0] rsv0;
        logic [4:0] drift_damping;
        logic [7:0] delay_comp_b;
        logic [7:0] delay_comp_a;
    } delay_decode_type;

    typedef struct packed {
        logic [4:0]  rsv1;
        logic [10:0] max_drift;
        logic [4:0]  rsv0;
        logic [10:0] startup_window;
    } startup_drift_type;

    typedef struct packed {
        logic [5:0] rsv1;
        logic [9:0] static_slot_count;
        logic [5:0] rsv0;
        logic [9:0] static_slot_len;
    } static_slot_type;

    // ------------------------------------------------------------------
    // Writable bit masks and reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] MASK_INITIAL_OFFSETS   = 32'h7F7FFFFF;
    localparam logic [DATA_W-1:0] MASK_IDLE_OFFSET_START = 32'h3FFF3FFF;
    localparam logic [DATA_W-1:0] MASK_DELAY_DECODE      = 32'hFF1FFFFF;
    localparam logic [DATA_W-1:0] MASK_STARTUP_DRIFT     = 32'h07FF07FF;
    localparam logic [DATA_W-1:0] MASK_STATIC_SLOT       = 32'h03FF03FF;

    localparam logic [DATA_W-1:0] RST_INITIAL_OFFSETS   = 32'h02020000;
    localparam logic [DATA_W-1:0] RST_IDLE_OFFSET_START = 32'h00080007;
    localparam logic [DATA_W-1:0] RST_DELAY_DECODE      = 32'h0E000000;
    localparam logic [DATA_W-1:0] RST_STARTUP_DRIFT     = 32'h00020000;
    localparam logic [DATA_W-1:0] RST_STATIC_SLOT       = 32'h00020004;

endpackage : time_unit_cfg_pkg

`default_nettype wire

// *** rtl/time_unit_config_regs.sv ***
// Time unit configuration register bank with an AXI4-Lite slave port
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none

module time_unit_config_regs
    import time_unit_cfg_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [DATA_W-1:0]     s_axi_wdata,
    input  wire logic [STRB_W-1:0]     s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0]     s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    // AXI4-Lite read data
    output logic [DATA_W-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // Controller state and macrotick timing
    input  wire logic                  default_config_state,
    input  wire logic                  config_state,
    input  wire logic [13:0]           macrotick_count,
    input  wire logic                  macrotick_pulse,
    // Configuration to the time unit
    output initial_offsets_type        initial_offsets_cfg,
    output idle_offset_start_type      idle_and_offset_start,
    output delay_decode_type           delay_decode_drift_cfg,
    output startup_drift_type          startup_range_drift_cfg,
    output static_slot_type            static_slot_cfg,
    output logic                       idle_start_pulse,
    output logic                       offset_corr_pulse
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [DATA_W-1:0] apply_write(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] data,
        input logic [STRB_W-1:0] strb,
        input logic [DATA_W-1:0] mask
    );
        logic [DATA_W-1:0] lanes;
        lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        apply_write = ((old_val & ~lanes) | (data & lanes)) & mask;
    endfunction : apply_write

    function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] addr);
        word_addr = {addr[ADDR_W-1:2], 2'h0};
    endfunction : word_addr

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    initial_offsets_type   init_ofs_reg;
    idle_offset_start_type idle_ofs_reg;
    delay_decode_type      delay_reg;
    startup_drift_type     startup_reg;
    static_slot_type       slot_reg;

    logic [ADDR_W-1:0]     awaddr_reg;
    logic [DATA_W-1:0]     wdata_reg;
    logic [STRB_W-1:0]     wstrb_reg;
    logic                  aw_held_reg;
    logic                  w_held_reg;
    logic                  awready_reg;
    logic                  wready_reg;
    logic                  bvalid_reg;
    logic [1:0]            bresp_reg;
    logic [ADDR_W-1:0]     araddr_reg;
    logic                  ar_held_reg;
    logic                  arready_reg;
    logic                  rvalid_reg;
    logic [DATA_W-1:0]     rdata_reg;
    logic [1:0]            rresp_reg;
    logic                  idle_pulse_reg;
    logic                  ocs_pulse_reg;

    logic                  cfg_open;
    logic                  wr_commit;
    logic                  wr_hit;
    logic [ADDR_W-1:0]     wr_addr;
    logic [ADDR_W-1:0]     rd_addr;

    assign cfg_open  = default_config_state || config_state;
    assign wr_commit = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_addr   = word_addr(awaddr_reg);
    assign rd_addr   = word_addr(araddr_reg);
    assign wr_hit    = (wr_addr == OFS_INITIAL_OFFSETS) || (wr_addr == OFS_IDLE_OFFSET_START)
                    || (wr_addr == OFS_DELAY_DECODE) || (wr_addr == OFS_STARTUP_DRIFT)
                    || (wr_addr == OFS_STATIC_SLOT);

    // ------------------------------------------------------------------
    // Write address and data channels
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_reg  <= '0;
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b0;
        end else if (s_axi_awvalid && awready_reg) begin
            awaddr_reg  <= s_axi_awaddr;
            aw_held_reg <= 1'b1;
            awready_reg <= 1'b0;
        end else if (bvalid_reg && s_axi_bready) begin
            aw_held_reg <= 1'b0;
            awready_reg <= 1'b1;
        end else if (!aw_held_reg) begin
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_reg  <= '0;
            wstrb_reg  <= '0;
            w_held_reg <= 1'b0;
            wready_reg <= 1'b0;
        end else if (s_axi_wvalid && wready_reg) begin
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
            w_held_reg <= 1'b1;
            wready_reg <= 1'b0;
        end else if (bvalid_reg && s_axi_bready) begin
            w_held_reg <= 1'b0;
            wready_reg <= 1'b1;
        end else if (!w_held_reg) begin
            wready_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (wr_commit) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    // Writes outside the configuration states complete on the bus but change nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_ofs_reg <= RST_INITIAL_OFFSETS;
            idle_ofs_reg <= RST_IDLE_OFFSET_START;
            delay_reg    <= RST_DELAY_DECODE;
            startup_reg  <= RST_STARTUP_DRIFT;
            slot_reg     <= RST_STATIC_SLOT;
        end else if (wr_commit && cfg_open) begin
            unique case (wr_addr)
                OFS_INITIAL_OFFSETS:   init_ofs_reg <= apply_write(init_ofs_reg, wdata_reg,
                                           wstrb_reg, MASK_INITIAL_OFFSETS);
                OFS_IDLE_OFFSET_START: idle_ofs_reg <= apply_write(idle_ofs_reg, wdata_reg,
                                           wstrb_reg, MASK_IDLE_OFFSET_START);
                OFS_DELAY_DECODE:      delay_reg <= apply_write(delay_reg, wdata_reg,
                                           wstrb_reg, MASK_DELAY_DECODE);
                OFS_STARTUP_DRIFT:     startup_reg <= apply_write(startup_reg, wdata_reg,
                                           wstrb_reg, MASK_STARTUP_DRIFT);
                OFS_STATIC_SLOT:       slot_reg <= apply_write(slot_reg, wdata_reg,
                                           wstrb_reg, MASK_STATIC_SLOT);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            araddr_reg  <= '0;
            ar_held_reg <= 1'b0;
            arready_reg <= 1'b0;
        end else if (s_axi_arvalid && arready_reg) begin
            araddr_reg  <= s_axi_araddr;
            ar_held_reg <= 1'b1;
            arready_reg <= 1'b0;
        end else if (rvalid_reg && s_axi_rready) begin
            ar_held_reg <= 1'b0;
            arready_reg <= 1'b1;
        end else if (!ar_held_reg) begin
            arready_reg <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end else if (ar_held_reg && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= RESP_OKAY;
            unique case (rd_addr)
                OFS_INITIAL_OFFSETS:   rdata_reg <= init_ofs_reg;
                OFS_IDLE_OFFSET_START: rdata_reg <= idle_ofs_reg;
                OFS_DELAY_DECODE:      rdata_reg <= delay_reg;
                OFS_STARTUP_DRIFT:     rdata_reg <= startup_reg;
                OFS_STATIC_SLOT:       rdata_reg <= slot_reg;
                default: begin
                    rdata_reg <= '0;
                    rresp_reg <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Macrotick match detection
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_pulse_reg <= 1'b0;
        end else begin
            idle_pulse_reg <= macrotick_pulse
                && (macrotick_count == idle_ofs_reg.idle_time_start);
        end
    end

    // Start of offset correction uses the value software placed inside the idle phase
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ocs_pulse_reg <= 1'b0;
        end else begin
            ocs_pulse_reg <= macrotick_pulse
                && (macrotick_count == idle_ofs_reg.offset_corr_start);
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready           = awready_reg;
    assign s_axi_wready            = wready_reg;
    assign s_axi_bvalid            = bvalid_reg;
    assign s_axi_bresp             = bresp_reg;
    assign s_axi_arready           = arready_reg;
    assign s_axi_rvalid            = rvalid_reg;
    assign s_axi_rdata             = rdata_reg;
    assign s_axi_rresp             = rresp_reg;
    assign initial_offsets_cfg     = init_ofs_reg;
    assign idle_and_offset_start   = idle_ofs_reg;
    assign delay_decode_drift_cfg  = delay_reg;
    assign startup_range_drift_cfg = startup_reg;
    assign static_slot_cfg         = slot_reg;
    assign idle_start_pulse        = idle_pulse_reg;
    assign offset_corr_pulse       = ocs_pulse_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    logic full_wr;
    assign full_wr = wr_commit && cfg_open && (wstrb_reg == 4'hF);

    AST_IDLE_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_IDLE_OFFSET_START)
        |=> idle_and_offset_start.idle_time_start == $past(wdata_reg[13:0]))
        else $error("idle start not updated by write in config state");

    AST_MICRO_A: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_INITIAL_OFFSETS)
        |=> initial_offsets_cfg.micro_init_offset_a == $past(wdata_reg[7:0]))
        else $error("microtick offset A not updated");

    AST_MACRO_B: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_INITIAL_OFFSETS)
        |=> initial_offsets_cfg.macro_init_offset_b == $past(wdata_reg[30:24]))
        else $error("macrotick offset B not updated");

    AST_IDLE_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
        idle_start_pulse |-> $past(macrotick_pulse)
        && ($past(macrotick_count) == $past(idle_ofs_reg.idle_time_start)))
        else $error("idle start pulse without match");

    AST_IDLE_MATCH: assert property (@(posedge aclk) disable iff (!aresetn)
        macrotick_pulse && (macrotick_count == idle_ofs_reg.idle_time_start)
        |=> idle_start_pulse ##1 (!idle_start_pulse || $past(macrotick_pulse)))
        else $error("idle start match missed");

    AST_DELAY_B: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_DELAY_DECODE)
        |=> delay_decode_drift_cfg.delay_comp_b == $past(wdata_reg[15:8]))
        else $error("delay compensation B not updated");

    AST_DAMPING: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_DELAY_DECODE)
        |=> delay_decode_drift_cfg.drift_damping == $past(wdata_reg[20:16]))
        else $error("drift damping not updated");

    AST_DECODE: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_DELAY_DECODE)
        |=> delay_decode_drift_cfg.primary_ref_adjust == $past(wdata_reg[31:24]))
        else $error("decoding correction not updated");

    AST_WINDOW: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_STARTUP_DRIFT)
        |=> startup_range_drift_cfg.startup_window == $past(wdata_reg[10:0]))
        else $error("startup range not updated");

    AST_DRIFT: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_STARTUP_DRIFT)
        |=> startup_range_drift_cfg.max_drift == $past(wdata_reg[26:16]))
        else $error("maximum drift not updated");

    AST_SLOT_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_STATIC_SLOT)
        |=> static_slot_cfg.static_slot_len == $past(wdata_reg[9:0]))
        else $error("static slot length not updated");

    AST_SLOT_CNT: assert property (@(posedge aclk) disable iff (!aresetn)
        full_wr && (wr_addr == OFS_STATIC_SLOT)
        |=> static_slot_cfg.static_slot_count == $past(wdata_reg[25:16]))
        else $error("static slot count not updated");

    AST_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_commit && !cfg_open
        |=> $stable(init_ofs_reg) && $stable(idle_ofs_reg) && $stable(delay_reg)
        && $stable(startup_reg) && $stable(slot_reg))
        else $error("register changed by write outside config state");

    AST_READ_BACK: assert property (@(posedge aclk) disable iff (!aresetn)
        ar_held_reg && !rvalid_reg && (rd_addr == OFS_STATIC_SLOT)
        |=> s_axi_rvalid && (s_axi_rdata == $past(slot_reg)))
        else $error("read does not return stored contents");

    COV_CFG_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_commit && cfg_open && wr_hit);
    COV_LOCKED_WRITE: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_commit && !cfg_open && wr_hit);
    COV_IDLE_PULSE: cover property (@(posedge aclk) disable iff (!aresetn)
        idle_start_pulse);
    COV_BAD_READ: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && (s_axi_rresp == RESP_SLVERR));

endmodule : time_unit_config_regs

`default_nettype wire

// *** bench/time_unit_config_regs_tb.sv ***
// Self-checking bench for the time unit configuration register bank
`default_nettype none
module time_unit_config_regs_tb
    import time_unit_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0, aresetn = 1'b0, dcs = 1'b0, cs = 1'b0, mpulse = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic [13:0] mcount = 14'h0;
    logic        awready, wready, bvalid, arready, rvalid, nit_p, ocs_p;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    initial_offsets_type   io;
    idle_offset_start_type ios;
    delay_decode_type      dd;
    startup_drift_type     sd;
    static_slot_type       ss;
    logic [31:0] msk [5] = '{MASK_INITIAL_OFFSETS, MASK_IDLE_OFFSET_START, MASK_DELAY_DECODE,
                             MASK_STARTUP_DRIFT, MASK_STATIC_SLOT};
    logic [31:0] expv [5] = '{RST_INITIAL_OFFSETS, RST_IDLE_OFFSET_START, RST_DELAY_DECODE,
                              RST_STARTUP_DRIFT, RST_STATIC_SLOT};
    int          err_total = 0;
    int          total_checks = 0;

    time_unit_config_regs time_unit_config_regs_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .default_config_state(dcs),
        .config_state(cs), .macrotick_count(mcount), .macrotick_pulse(mpulse),
        .initial_offsets_cfg(io), .idle_and_offset_start(ios), .delay_decode_drift_cfg(dd),
        .startup_range_drift_cfg(sd), .static_slot_cfg(ss), .idle_start_pulse(nit_p),
        .offset_corr_pulse(ocs_p));

    always #10 aclk = ~aclk;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] d, logic [3:0] s,
                                          logic [31:0] m);
        for (int b = 0; b < 4; b++)
            if (s[b]) o[8*b+:8] = d[8*b+:8];
        return o & m;
    endfunction : merge

    task automatic chk(input logic [159:0] got, input logic [159:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 50);
        chk(160'(n < 50), 160'h1, "write handshake");
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 50);
        chk(160'(n < 50), 160'h1, "read handshake");
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [1:0]  r, st;
        logic [31:0] d, v;
        logic [7:0]  a;
        logic [3:0]  s;
        logic [13:0] t, o;
        int          k;
        void'($urandom(87));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(8'hA8 + 8'(4 * i), v, r);
            chk(v, expv[i], "reset value");
        end
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            dcs <= i[0];
            cs <= ~i[0];
            wr(8'hA8 + 8'(4 * i), 32'hFFFFFFFF, 4'hF, r);
            expv[i] = msk[i];
            rd(8'hA8 + 8'(4 * i), v, r);
            chk(v, expv[i], "field widths");
        end
        $display("test widths done");
        for (int i = 0; i < 60; i++) begin
            k = $urandom % 6;
            a = ((k == 5) ? 8'hBC : 8'hA8 + 8'(4 * k)) | 8'($urandom % 4);
            d = $urandom;
            s = 4'($urandom);
            st = 2'($urandom);
            {dcs, cs} <= st;
            wr(a, d, s, r);
            if (k < 5 && st != 2'h0) expv[k] = merge(expv[k], d, s, msk[k]);
            chk(r, (k == 5) ? RESP_SLVERR : RESP_OKAY, "bresp");
            rd(a, v, r);
            chk(v, (k == 5) ? 32'h0 : expv[k % 5], "rdata");
            chk(r, (k == 5) ? RESP_SLVERR : RESP_OKAY, "rresp");
            chk({ss, sd, dd, ios, io}, {expv[4], expv[3], expv[2], expv[1], expv[0]},
                "outputs");
        end
        $display("test random access done");
        for (int i = 0; i < 8; i++) begin
            t = 14'(7 + $urandom % 15991);
            o = t + 14'h1;
            dcs <= 1'b0;
            cs <= 1'b1;
            wr(OFS_IDLE_OFFSET_START, {2'h0, o, 2'h0, t}, 4'hF, r);
            mcount <= t;
            mpulse <= i[0];
            @(posedge aclk);
            mcount <= o;
            mpulse <= i[1];
            @(posedge aclk);
            mpulse <= 1'b0;
            mcount <= ~t;
            chk(nit_p, i[0], "idle start pulse");
            @(posedge aclk);
            chk({nit_p, ocs_p}, {1'b0, i[1]}, "offset correction pulse");
            @(posedge aclk);
            chk({nit_p, ocs_p}, 2'h0, "pulse width");
        end
        $display("test idle start done");
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end
endmodule : time_unit_config_regs_tb
`default_nettype wire
